// >>> shared/pbc_pkg.sv
// pbc_pkg: constants, register map and state codes of the push-button sequencer
// assumes one 100 MHz system clock; all counts are in cycles of that clock
package pbc_pkg;

  // ----------------------------------------------------------------
  // clock and waits
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS    = 10;
  localparam int unsigned POWERUP_WAIT_US  = 25000;
  localparam int unsigned DEBOUNCE_WAIT_US = 20000;
  // least times: round up to whole cycles
  localparam int unsigned POWERUP_WAIT_CYC =
    (POWERUP_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DEBOUNCE_WAIT_CYC =
    (DEBOUNCE_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // message memory address
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W    = 10;
  localparam logic [9:0]  ADDR_ZERO = 10'h000;
  localparam logic [9:0]  ADDR_ONE  = 10'h001;
  localparam logic [9:0]  ADDR_MAX  = 10'h2FF;
  localparam logic [1:0]  MODE_MSB_ON = 2'h3;

  // ----------------------------------------------------------------
  // apb register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0]  REG_CTRL   = 8'h00;
  localparam logic [7:0]  REG_STATUS = 8'h04;
  localparam logic [7:0]  REG_ADDR   = 8'h08;
  localparam logic [7:0]  REG_PULSES = 8'h0C;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] RD_ZERO    = 32'h0000_0000;
  localparam int unsigned CTRL_HOLD_BIT  = 0;
  localparam int unsigned STAT_STATE_LSB = 0;
  localparam int unsigned STAT_RUN_BIT   = 4;
  localparam int unsigned STAT_REC_BIT   = 5;
  localparam int unsigned STAT_OVF_BIT   = 6;
  localparam int unsigned STAT_PD_BIT    = 7;
  localparam int unsigned STAT_MODE_BIT  = 8;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_WAKE  = 4'b0010,
    ST_RUN   = 4'b0100,
    ST_PAUSE = 4'b1000
  } pbc_state_e;

endpackage

// >>> hw/pbc_sync_edge.sv
// pbc_sync_edge: two-flop synchroniser with edge detection for one button pin
// assumes the pin may change at any time; INIT is the pin's idle level
`timescale 1ns/1ps
module pbc_sync_edge #(
  parameter logic INIT = 1'b0
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic pinIn,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic meta_r;
  logic sync_r;
  logic last_r;

  // meta_r feeds sync_r only
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      meta_r <= INIT;
      sync_r <= INIT;
      last_r <= INIT;
    end else begin
      meta_r <= pinIn;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  assign level = sync_r;
  assign rise  = sync_r & ~last_r;
  assign fall  = ~sync_r & last_r;
endmodule // pbc_sync_edge

// >>> hw/pbc_wait_timer.sv
// pbc_wait_timer: counts cycles while run is high, done once CYCLES are reached
// assumes run drops to restart; count saturates so done stays up
`timescale 1ns/1ps
module pbc_wait_timer #(
  parameter int unsigned CYCLES = 1
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic run,
  output logic      done
);
  logic [31:0] cnt_r;

  always_ff @(posedge clk_sys) begin
    if (!rst_n || !run) begin
      cnt_r <= 32'h0000_0000;
    end else if (cnt_r != CYCLES) begin
      cnt_r <= cnt_r + 32'h0000_0001;
    end
  end

  assign done = (cnt_r == CYCLES);
endmodule // pbc_wait_timer

// >>> hw/pbc_top.sv
// pbc_top: push-button start/pause/stop sequencer of a voice record/play device
// assumes pins are synchronous to clk_sys except the two buttons, which are
// synchronised here; the memory side steps the address and reports markers
//
// Notes on behaviour
// - button mode needs both msbs and mode pin
// - powers down after every cycle, start high
// - start pulse when idle begins play or record
// - second pulse pauses, address kept
// - next pulse resumes at paused address
// - stop pulse ends cycle, address to zero
// - run indicator high only while operating
// - record pause writes marker, keeps pointer
// - record pause then play starts at zero
// - record resume writes after previous marker
// - record end by start or stop marks end
// - playback marker pauses, run indicator low
// - record after play pause keeps address
// - overflow then start replays from zero
// - power-up wait before playing or recording
// - new start ignored until debounce elapsed
// - no power-down before start high debounce
// - pulses alternate start, pause, resume
// - stop level halts, clears address, powers down
// - merge mode erases marker, records there
// - works with cue, merge, loop modes
// - select high plays, low records
`timescale 1ns/1ps
module pbc_top #(
  parameter int unsigned PWRUP_CYC    = pbc_pkg::POWERUP_WAIT_CYC,
  parameter int unsigned DEBOUNCE_CYC = pbc_pkg::DEBOUNCE_WAIT_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // button and mode pins
  input  wire logic        startPauseN,
  input  wire logic        stopResetIn,
  input  wire logic        playRecSel,
  input  wire logic [1:0]  addrMsb,
  input  wire logic        buttonModePin,
  input  wire logic        cueModePin,
  input  wire logic        markerMergePin,
  input  wire logic        reservedModePin,
  input  wire logic        loopModePin,
  // memory side
  input  wire logic        addrStep,
  input  wire logic        markerHit,
  output logic             runInd,
  output logic             powerDown,
  output logic             recMode,
  output logic             overflowFlag,
  output logic             markerWrite,
  output logic             markerErase,
  output logic [9:0]       addrPtr
);
  import pbc_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  pbc_state_e  state_r;
  pbc_state_e  state_nxt;
  logic [9:0]  addr_r;
  logic [9:0]  addr_nxt;
  logic        rec_r;
  logic        rec_nxt;
  logic        ovf_r;
  logic        ovf_nxt;
  logic        pd_r;
  logic        pd_nxt;
  logic        run_r;
  logic        mWr_r;
  logic        mWr_nxt;
  logic        mEr_r;
  logic        mEr_nxt;
  logic [7:0]  pulses_r;
  logic        hold_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  logic        startLvl;
  logic        startFall;
  logic        stopLvl;
  logic        dbDone;
  logic        wakeDone;
  logic        modeOk;
  logic        active;
  logic        halt;
  logic        startEv;
  logic        newRec;
  logic        apbSetup;
  logic        apbWrite;

  // ----------------------------------------------------------------
  // button inputs
  // ----------------------------------------------------------------
  pbc_sync_edge #(.INIT(1'b1)) uStartSync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .pinIn   (startPauseN),
    .level   (startLvl),
    .rise    (),
    .fall    (startFall)
  );

  pbc_sync_edge #(.INIT(1'b0)) uStopSync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .pinIn   (stopResetIn),
    .level   (stopLvl),
    .rise    (),
    .fall    ()
  );

  // debounce: start must sit high this long before a new fall counts
  pbc_wait_timer #(.CYCLES(DEBOUNCE_CYC)) uDebounce (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .run     (startLvl),
    .done    (dbDone)
  );

  pbc_wait_timer #(.CYCLES(PWRUP_CYC)) uPowerup (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .run     (state_r == ST_WAKE),
    .done    (wakeDone)
  );

  // reserved mode pin is the other party's to hold low; not looked at
  assign modeOk  = (addrMsb == MODE_MSB_ON) && buttonModePin;
  assign active  = modeOk && !hold_r;
  assign halt    = stopLvl || !active;
  // dbDone still reflects the high time before this fall
  assign startEv = startFall && dbDone && active;
  assign newRec  = !playRecSel;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    addr_nxt  = addr_r;
    rec_nxt   = rec_r;
    ovf_nxt   = ovf_r;
    pd_nxt    = pd_r;
    mWr_nxt   = 1'b0;
    mEr_nxt   = 1'b0;
    if (halt) begin
      mWr_nxt   = (state_r == ST_RUN) && rec_r;
      state_nxt = ST_IDLE;
      addr_nxt  = ADDR_ZERO;
      ovf_nxt   = 1'b0;
      pd_nxt    = 1'b1;
    end else begin
      case (state_r)
        ST_IDLE: begin
          pd_nxt = 1'b1;
          if (startEv) begin
            rec_nxt   = newRec;
            addr_nxt  = ADDR_ZERO;
            state_nxt = ST_WAKE;
            pd_nxt    = 1'b0;
          end
        end
        ST_WAKE: begin
          pd_nxt = 1'b0;
          if (wakeDone) begin
            state_nxt = ST_RUN;
          end
        end
        ST_RUN: begin
          if (startEv) begin
            state_nxt = ST_PAUSE;
            mWr_nxt   = rec_r;
          end else if (!rec_r && markerHit) begin
            // loop restarts at zero, cue skips past, else pause
            if (loopModePin) begin
              addr_nxt = ADDR_ZERO;
            end else if (cueModePin) begin
              addr_nxt = 10'(addr_r + ADDR_ONE);
            end else begin
              state_nxt = ST_PAUSE;
            end
          end else if (addrStep) begin
            if (addr_r != ADDR_MAX) begin
              addr_nxt = 10'(addr_r + ADDR_ONE);
            end else if (!rec_r && loopModePin) begin
              addr_nxt = ADDR_ZERO;
            end else begin
              ovf_nxt   = 1'b1;
              state_nxt = ST_PAUSE;
            end
          end
        end
        ST_PAUSE: begin
          // power-down waits for start to settle high
          if (dbDone) begin
            pd_nxt = 1'b1;
          end
          if (startEv) begin
            state_nxt = ST_WAKE;
            pd_nxt    = 1'b0;
            rec_nxt   = newRec;
            if (ovf_r) begin
              addr_nxt = ADDR_ZERO;
              rec_nxt  = 1'b0;
              ovf_nxt  = 1'b0;
            end else if (rec_r && !newRec) begin
              addr_nxt = ADDR_ZERO;
            end else if (rec_r && markerMergePin) begin
              mEr_nxt  = 1'b1;
            end else if (rec_r) begin
              addr_nxt = 10'(addr_r + ADDR_ONE);
            end
            // play pause: address kept for either direction
          end
        end
        default: begin
          state_nxt = ST_IDLE;
          pd_nxt    = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      addr_r <= ADDR_ZERO;
      rec_r  <= 1'b0;
      ovf_r  <= 1'b0;
    end else begin
      addr_r <= addr_nxt;
      rec_r  <= rec_nxt;
      ovf_r  <= ovf_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pd_r  <= 1'b1;
      run_r <= 1'b0;
      mWr_r <= 1'b0;
      mEr_r <= 1'b0;
    end else begin
      pd_r  <= pd_nxt;
      run_r <= (state_nxt == ST_RUN);
      mWr_r <= mWr_nxt;
      mEr_r <= mEr_nxt;
    end
  end

  // accepted start pulses since the last stop; bit0 set means the last one
  // started or resumed while no marker hit or overflow paused the run: odd counts start/resume, even ones pause
  always_ff @(posedge clk_sys) begin
    if (!rst_n || halt) begin
      pulses_r <= 8'h00;
    end else if (startEv && state_r != ST_WAKE) begin
      pulses_r <= 8'(pulses_r + 8'h01);
    end
  end

  // ----------------------------------------------------------------
  // apb slave, no wait states
  // ----------------------------------------------------------------
  assign apbSetup = psel && !penable;
  assign apbWrite = psel && penable && pready_r && pwrite;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= apbSetup;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      hold_r <= CTRL_RESET[CTRL_HOLD_BIT];
    end else if (apbWrite && paddr == REG_CTRL) begin
      hold_r <= pwdata[CTRL_HOLD_BIT];
    end
  end

  // read data is captured in the setup phase and stands through access
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      prdata_r  <= RD_ZERO;
      pslverr_r <= 1'b0;
    end else if (apbSetup) begin
      prdata_r  <= RD_ZERO;
      pslverr_r <= 1'b0;
      case (paddr)
        REG_CTRL: begin
          prdata_r[CTRL_HOLD_BIT] <= hold_r;
        end
        REG_STATUS: begin
          prdata_r[STAT_STATE_LSB +: 4] <= state_r;
          prdata_r[STAT_RUN_BIT]        <= run_r;
          prdata_r[STAT_REC_BIT]        <= rec_r;
          prdata_r[STAT_OVF_BIT]        <= ovf_r;
          prdata_r[STAT_PD_BIT]         <= pd_r;
          prdata_r[STAT_MODE_BIT]       <= modeOk;
        end
        REG_ADDR: begin
          prdata_r[9:0] <= addr_r;
        end
        REG_PULSES: begin
          prdata_r[7:0] <= pulses_r;
        end
        default: begin
          pslverr_r <= 1'b1;
        end
      endcase
    end
  end

  assign prdata       = prdata_r;
  assign pready       = pready_r;
  assign pslverr      = pslverr_r;
  assign runInd       = run_r;
  assign powerDown    = pd_r;
  assign recMode      = rec_r;
  assign overflowFlag = ovf_r;
  assign markerWrite  = mWr_r;
  assign markerErase  = mEr_r;
  assign addrPtr      = addr_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  int unsigned wakeLen;
  always_ff @(posedge clk_sys) begin
    if (!rst_n || state_r != ST_WAKE) begin
      wakeLen <= 0;
    end else begin
      wakeLen <= wakeLen + 1;
    end
  end

  sequence s_run_start;
    state_r == ST_RUN && startEv && !halt;
  endsequence
  sequence s_paused;
    state_r == ST_PAUSE && !run_r;
  endsequence

  property p_mode_gate;
    !modeOk |=> state_r == ST_IDLE && !run_r;
  endproperty
  a_mode_gate: assert property (p_mode_gate) else $error("left idle outside button mode");

  property p_stop_clears;
    stopLvl |=> addr_r == ADDR_ZERO && pd_r && !run_r;
  endproperty
  a_stop_clears: assert property (p_stop_clears) else $error("stop did not clear and power down");

  property p_pwrup_len;
    state_r == ST_WAKE && !halt ##1 state_r == ST_RUN |-> $past(wakeLen) == PWRUP_CYC;
  endproperty
  a_pwrup_len: assert property (p_pwrup_len) else $error("power-up wait length wrong");

  property p_pause_keeps;
    s_run_start |=> s_paused and addr_r == $past(addr_r);
  endproperty
  a_pause_keeps: assert property (p_pause_keeps) else $error("pause moved the address");

  property p_rec_marker;
    s_run_start and rec_r |=> markerWrite && !runInd;
  endproperty
  a_rec_marker: assert property (p_rec_marker) else $error("record pause wrote no marker");

  property p_eom_pause;
    state_r == ST_RUN && !rec_r && markerHit && !startEv && !halt && !cueModePin && !loopModePin
      |=> s_paused ##1 !run_r;
  endproperty
  a_eom_pause: assert property (p_eom_pause) else $error("marker did not pause playback");

  property p_ovf_restart;
    state_r == ST_PAUSE && ovf_r && startEv && !halt
      |=> state_r == ST_WAKE && addr_r == ADDR_ZERO && !rec_r && !ovf_r;
  endproperty
  a_ovf_restart: assert property (p_ovf_restart) else $error("overflow restart wrong");

  property p_debounce;
    startFall && !dbDone && !halt |=> state_r == $past(state_r) && pulses_r == $past(pulses_r);
  endproperty
  a_debounce: assert property (p_debounce) else $error("bouncing start was accepted");

  property p_pd_wait;
    state_r == ST_PAUSE && !pd_r && !dbDone && !halt |=> !pd_r;
  endproperty
  a_pd_wait: assert property (p_pd_wait) else $error("power-down before debounce");

  property p_rec_resume;
    state_r == ST_PAUSE && rec_r && !ovf_r && newRec && !markerMergePin && startEv && !halt
      |=> addr_r == 10'($past(addr_r) + ADDR_ONE) ##[1:2] state_r == ST_WAKE;
  endproperty
  a_rec_resume: assert property (p_rec_resume) else $error("record resume address wrong");

endmodule // pbc_top

// >>> test/pbc_button_model.sv
// pbc_button_model: push-buttons and memory side facing the sequencer
// assumes the bench gives one-cycle go strobes after a rising edge
`timescale 1ns/1ps
module pbc_button_model (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic pressGo,
  input  wire logic stopGo,
  input  wire logic stepGo,
  input  wire logic markGo,
  output logic      startPauseN,
  output logic      stopResetIn,
  output logic      addrStep,
  output logic      markerHit
);
  // ----------------------------------------------------------------
  // button pulses
  // ----------------------------------------------------------------
  logic [1:0] pressCnt_r;
  logic [1:0] stopCnt_r;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pressCnt_r <= 2'h0;
    end else if (pressGo) begin
      pressCnt_r <= 2'h3;
    end else if (pressCnt_r != 2'h0) begin
      pressCnt_r <= pressCnt_r - 2'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      stopCnt_r <= 2'h0;
    end else if (stopGo) begin
      stopCnt_r <= 2'h3;
    end else if (stopCnt_r != 2'h0) begin
      stopCnt_r <= stopCnt_r - 2'h1;
    end
  end

  // start idles high between presses; the bench spaces presses
  assign startPauseN = (pressCnt_r == 2'h0);
  // pull-down keeps stop low except for its short pulse
  assign stopResetIn = (stopCnt_r != 2'h0);

  // ----------------------------------------------------------------
  // memory side strobes
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      addrStep  <= 1'b0;
      markerHit <= 1'b0;
    end else begin
      addrStep  <= stepGo;
      markerHit <= markGo;
    end
  end
endmodule // pbc_button_model

// >>> test/pbc_top_tb_top.sv
// pbc_top_tb_top: self-checking bench of the push-button sequencer
// assumes short power-up and debounce parameters; apb reads checked from a queue
`timescale 1ns/1ps
module pbc_top_tb_top;
  import pbc_pkg::*;
  localparam int unsigned PWRUP = 20;
  localparam int unsigned DEB   = 8;
  logic        clk_sys, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rnd;
  logic        startPauseN, stopResetIn, playRecSel, buttonModePin, markerMergePin;
  logic        loopModePin, cueModePin;
  logic        addrStep, markerHit, runInd, powerDown, recMode, overflowFlag;
  logic        markerWrite, markerErase, pressGo, stopGo, stepGo, markGo;
  logic [9:0]  addrPtr;
  logic [32:0] expQ[$];
  logic [32:0] expV;
  int          errors, check_count, mwCnt, meCnt, n;

  pbc_top #(.PWRUP_CYC(PWRUP), .DEBOUNCE_CYC(DEB)) dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .startPauseN(startPauseN), .stopResetIn(stopResetIn), .playRecSel(playRecSel),
    .addrMsb(MODE_MSB_ON), .buttonModePin(buttonModePin), .cueModePin(cueModePin),
    .markerMergePin(markerMergePin), .reservedModePin(1'b0), .loopModePin(loopModePin),
    .addrStep(addrStep), .markerHit(markerHit), .runInd(runInd), .powerDown(powerDown),
    .recMode(recMode), .overflowFlag(overflowFlag), .markerWrite(markerWrite),
    .markerErase(markerErase), .addrPtr(addrPtr));

  pbc_button_model model_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .pressGo(pressGo), .stopGo(stopGo), .stepGo(stepGo),
    .markGo(markGo), .startPauseN(startPauseN), .stopResetIn(stopResetIn),
    .addrStep(addrStep), .markerHit(markerHit));

  // ----------------------------------------------------------------
  // compare and report
  // ----------------------------------------------------------------
  task automatic fail(input string what);
    errors++;
    $display("BAD %0t %s", $time, what);
  endtask
  task automatic chk_bus(input logic [32:0] got, input logic [32:0] exp, input string what);
    check_count++;
    if (got !== exp) fail($sformatf("%s got %h exp %h", what, got, exp));
  endtask
  task automatic chk_pin(input logic got, input logic exp, input string what);
    check_count++;
    if (got !== exp) fail($sformatf("%s got %b", what, got));
  endtask
  task automatic chk_cnt(input int got, input int exp, input string what);
    check_count++;
    if (got != exp) fail($sformatf("%s count %0d exp %0d", what, got, exp));
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // oldest note meets each apb answer; write data is not compared
  always @(posedge clk_sys) begin
    if (psel && penable && pready === 1'b1) begin
      expV = expQ.pop_front();
      if (pwrite) chk_bus({pslverr, 32'h0000_0000}, {expV[32], 32'h0000_0000}, "apb wr");
      else chk_bus({pslverr, prdata}, expV, "apb rd");
    end
    if (markerWrite === 1'b1) mwCnt++;
    if (markerErase === 1'b1) meCnt++;
  end

  // ----------------------------------------------------------------
  // drivers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    expQ.push_back(e);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // no cycle count assumed; a hang is the watchdog's to catch
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000, {1'b0, e});
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge clk_sys);
  endtask
  task automatic pulse(input int which, input int times);
    repeat (times) begin
      @(posedge clk_sys);
      case (which)
        0: pressGo <= 1'b1;
        1: stopGo  <= 1'b1;
        2: stepGo  <= 1'b1;
        default: markGo <= 1'b1;
      endcase
      @(posedge clk_sys);
      {pressGo, stopGo, stepGo, markGo} <= 4'h0;
    end
    if (which < 2) cyc(4);
  endtask
  task automatic wait_run(input logic e);
    for (int i = 0; i < 100 && runInd !== e; i++) @(posedge clk_sys);
    chk_pin(runInd, e, "run indicator");
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog, tests
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    #600_000;
    fail("watchdog");
    wrap_up();
  end
  initial begin
    {psel, penable, pwrite, pressGo, stopGo, stepGo, markGo, markerMergePin} = 8'h00;
    {rst_n, paddr, pwdata, playRecSel, buttonModePin, loopModePin, cueModePin} = 0;
    buttonModePin = 1'b1;
    rnd = 32'h0000_0061;
    {errors, check_count, mwCnt, meCnt} = 0;
    cyc(3);
    rst_n <= 1'b1;
    rd(REG_CTRL, CTRL_RESET);
    rd(REG_STATUS, 32'h0000_0181);
    rd(REG_ADDR, RD_ZERO);
    rnd = xs(rnd);
    apb(1'b1, REG_STATUS, rnd, {1'b0, 32'h0000_0000});
    apb(1'b0, 8'h10, 32'h0000_0000, {1'b1, 32'h0000_0000});
    apb(1'b1, 8'h14, rnd, {1'b1, 32'h0000_0000});
    apb(1'b1, REG_CTRL, 32'h0000_0001, {1'b0, 32'h0000_0000});
    rd(REG_CTRL, 32'h0000_0001);
    apb(1'b1, REG_CTRL, RD_ZERO, {1'b0, 32'h0000_0000});
    rd(REG_STATUS, 32'h0000_0181);
    $display("test reset done");
    // record, pause, ignored quick press, resume
    cyc(DEB + 8);
    pulse(0, 1);
    wait_run(1'b1);
    rd(REG_STATUS, 32'h0000_0134);
    rnd = xs(rnd);
    n = int'(rnd % 7) + 1;
    pulse(2, n);
    rd(REG_ADDR, n);
    pulse(0, 1);
    wait_run(1'b0);
    chk_pin(powerDown, 1'b0, "early power-down");
    cyc(1);
    chk_cnt(mwCnt, 1, "pause marker");
    pulse(0, 1);
    cyc(DEB + 8);
    rd(REG_STATUS, 32'h0000_01A8);
    rd(REG_ADDR, n);
    rd(REG_PULSES, 32'h0000_0002);
    pulse(0, 1);
    wait_run(1'b1);
    rd(REG_ADDR, n + 1);
    rd(REG_PULSES, 32'h0000_0003);
    pulse(1, 1);
    cyc(1);
    chk_cnt(mwCnt, 2, "stop marker");
    chk_pin(runInd, 1'b0, "run after stop");
    chk_pin(powerDown, 1'b1, "stop power-down");
    rd(REG_ADDR, RD_ZERO);
    $display("test record done");
    // playback to marker, record on, record pause then play from zero
    playRecSel <= 1'b1;
    cyc(DEB + 8);
    pulse(0, 1);
    wait_run(1'b1);
    rd(REG_STATUS, 32'h0000_0114);
    pulse(2, 5);
    pulse(3, 1);
    wait_run(1'b0);
    rd(REG_ADDR, 32'h0000_0005);
    playRecSel <= 1'b0;
    cyc(DEB + 8);
    pulse(0, 1);
    wait_run(1'b1);
    rd(REG_ADDR, 32'h0000_0005);
    rd(REG_STATUS, 32'h0000_0134);
    pulse(2, 2);
    pulse(0, 1);
    wait_run(1'b0);
    playRecSel <= 1'b1;
    cyc(DEB + 8);
    pulse(0, 1);
    wait_run(1'b1);
    rd(REG_ADDR, RD_ZERO);
    pulse(1, 1);
    $display("test playback done");
    // marker merge while recording
    markerMergePin <= 1'b1;
    playRecSel <= 1'b0;
    cyc(DEB + 8);
    pulse(0, 1);
    wait_run(1'b1);
    chk_pin(recMode, 1'b1, "rec mode");
    pulse(2, 3);
    pulse(0, 1);
    cyc(DEB + 8);
    pulse(0, 1);
    cyc(1);
    chk_cnt(meCnt, 1, "merge erase");
    rd(REG_ADDR, 32'h0000_0003);
    chk_bus({23'h00_0000, addrPtr}, {23'h00_0000, 10'h003}, "addr pin");
    pulse(1, 1);
    markerMergePin <= 1'b0;
    $display("test merge done");
    // loop then cue: a marker no longer pauses playback
    playRecSel <= 1'b1;
    loopModePin <= 1'b1;
    cyc(DEB + 8);
    pulse(0, 1);
    wait_run(1'b1);
    pulse(2, 4);
    pulse(3, 1);
    cyc(4);
    rd(REG_ADDR, RD_ZERO);
    {loopModePin, cueModePin} <= 2'b01;
    pulse(3, 1);
    cyc(4);
    rd(REG_ADDR, 32'h0000_0001);
    chk_pin(runInd, 1'b1, "mode marker run");
    cueModePin <= 1'b0;
    pulse(1, 1);
    $display("test modes done");
    // overflow in playback, then restart from zero
    playRecSel <= 1'b1;
    cyc(DEB + 8);
    pulse(0, 1);
    wait_run(1'b1);
    pulse(2, int'(ADDR_MAX) + 1);
    cyc(4);
    chk_pin(overflowFlag, 1'b1, "overflow");
    wait_run(1'b0);
    cyc(DEB + 8);
    pulse(0, 1);
    wait_run(1'b1);
    rd(REG_ADDR, RD_ZERO);
    pulse(1, 1);
    $display("test overflow done");
    // button mode off: presses have no effect
    buttonModePin <= 1'b0;
    cyc(DEB + 8);
    pulse(0, 1);
    cyc(PWRUP + 20);
    chk_pin(runInd, 1'b0, "mode off run");
    rd(REG_STATUS, 32'h0000_0081);
    $display("test mode done");
    wrap_up();
  end
endmodule // pbc_top_tb_top
